// >>> core/pnpp_pkg.sv
// constants, command codes and carrier types for the parallel programming port
// assumes one 20 MHz clock; all pin inputs already synchronous to it
package pnpp_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int ENABLE_HOLD_NS = 100;
    localparam int ENABLE_HOLD_CYC_I = (ENABLE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] ENABLE_HOLD_CYC = ENABLE_HOLD_CYC_I[2:0];
    localparam logic [2:0] MIN_LOAD_TOGGLES = 3'h6;

    // ------------------------------------------------------------
    // widths and page geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 24;
    localparam int PAGE_WORD_BITS = 7;
    localparam int PAGE_WORDS = 128;
    localparam int EE_PAGE_BITS = 3;
    localparam logic [3:0] ENABLE_PATTERN = 4'h0;

    // ------------------------------------------------------------
    // action selector and byte select codes, {hi, lo}
    // ------------------------------------------------------------
    localparam logic [1:0] ACT_ADDR = 2'h0;
    localparam logic [1:0] ACT_DATA = 2'h1;
    localparam logic [1:0] ACT_CMD = 2'h2;
    localparam logic [1:0] ACT_IDLE = 2'h3;
    localparam logic [1:0] BSEL_LOW = 2'h0;
    localparam logic [1:0] BSEL_HIGH = 2'h1;
    localparam logic [1:0] BSEL_EXT = 2'h2;
    localparam logic [1:0] BSEL_RSVD = 2'h3;

    // ------------------------------------------------------------
    // command bytes
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_NOP = 8'h00;
    localparam logic [7:0] CMD_CHIP_ERASE = 8'h80;
    localparam logic [7:0] CMD_WRITE_FUSE = 8'h40;
    localparam logic [7:0] CMD_WRITE_LOCK = 8'h20;
    localparam logic [7:0] CMD_WRITE_FLASH = 8'h10;
    localparam logic [7:0] CMD_WRITE_EEPROM = 8'h11;
    localparam logic [7:0] CMD_READ_SIG = 8'h08;
    localparam logic [7:0] CMD_READ_FUSE = 8'h04;
    localparam logic [7:0] CMD_READ_FLASH = 8'h02;
    localparam logic [7:0] CMD_READ_EEPROM = 8'h03;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_NONE,
        OP_ERASE_FLASH,
        OP_ERASE_EEPROM,
        OP_ERASE_LOCK,
        OP_WRITE_FLASH_PAGE,
        OP_WRITE_EEPROM_PAGE,
        OP_WRITE_FUSE,
        OP_WRITE_LOCK
    } pnpp_op_kind_t;

    typedef struct packed {
        pnpp_op_kind_t kind;
        logic [ADDR_W-1:0] addr;
        logic [7:0] data;
        logic [1:0] fuse_sel;
    } pnpp_op_t;

    typedef enum logic [1:0] {
        RD_NONE,
        RD_FLASH,
        RD_EEPROM,
        RD_SIGNATURE
    } pnpp_rd_space_t;

    typedef struct packed {
        pnpp_rd_space_t space;
        logic [ADDR_W-1:0] addr;
    } pnpp_rd_req_t;

    typedef struct packed {
        logic [7:0] fuse_low;
        logic [7:0] fuse_high;
        logic [7:0] fuse_ext;
        logic [7:0] lock;
    } pnpp_fuse_lock_t;

endpackage

// >>> core/pnpp_page_buf.sv
// page buffer: one write port from the pin side, one registered read port
// assumes the array back end reads it only while a page write is in progress
`timescale 1ns/1ps
module pnpp_page_buf
    import pnpp_pkg::*;
(
    input wire logic i_clk, // system clock
    input wire logic i_ce, // clock enable
    input wire logic i_we, // write strobe
    input wire logic [PAGE_WORD_BITS-1:0] i_waddr, // write word index
    input wire logic [15:0] i_wdata, // write word
    input wire logic [PAGE_WORD_BITS-1:0] i_raddr, // read word index
    output logic [15:0] o_rdata // read word, one cycle after address
);

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    // no reset: contents are undefined until latched, as in the array
    logic [15:0] mem [PAGE_WORDS];

    always_ff @(posedge i_clk) begin
        if (i_ce && i_we) begin
            mem[i_waddr] <= i_wdata;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_ce) begin
            o_rdata <= mem[i_raddr];
        end
    end

endmodule // pnpp_page_buf

// >>> core/pnpp_port.sv
// device side of the high-voltage parallel programming port
// assumes all pin inputs synchronous to i_clk and an array back end that
// carries out each requested operation and pulses i_op_done when finished
`timescale 1ns/1ps
module pnpp_port
    import pnpp_pkg::*;
(
    input wire logic i_clk, // system clock, 20 MHz
    input wire logic i_rst, // synchronous reset, active high
    input wire logic i_ce, // clock enable, freezes all state when low
    input wire logic i_prog_voltage, // reset pin at programming level
    input wire logic i_load_clock_pin, // load clock, acts on rising edge
    input wire logic i_action_select0, // action selector bit 0
    input wire logic i_action_select1, // action selector bit 1
    input wire logic i_byte_select_lo, // byte select, low bit
    input wire logic i_byte_select_hi, // byte select, high bit
    input wire logic i_page_latch_strobe, // page latch, acts on rising edge
    input wire logic i_wr_n, // write strobe, acts on falling edge
    input wire logic i_oe_n, // output enable, active low
    input wire logic [7:0] i_data, // data bus input
    output logic [7:0] o_data, // data bus output value
    output logic o_data_oe, // data bus driven while high
    output logic o_ready_busy_out, // 1 ready, 0 busy
    output logic o_prog_mode, // programming mode entered
    input wire logic i_eeprom_preserve_fuse, // preserve fuse, 0 = programmed
    input wire pnpp_fuse_lock_t i_fuse_lock, // current fuse and lock bytes
    output pnpp_op_t o_op, // operation for the array back end
    output logic o_op_valid, // operation pending, level
    input wire logic i_op_done, // back end finished, one-cycle pulse
    output pnpp_rd_req_t o_rd_req, // read space and address
    input wire logic [15:0] i_rd_word, // word read from requested space
    input wire logic [7:0] i_cal_byte, // calibration byte
    input wire logic [PAGE_WORD_BITS-1:0] i_pbuf_raddr, // page buffer read index
    output logic [15:0] o_pbuf_rdata // page buffer read word
);

    // ------------------------------------------------------------
    // pin decode and edge detection
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_OFF,
        ST_GUARD,
        ST_REFUSED,
        ST_READY,
        ST_OP
    } pnpp_state_t;

    pnpp_state_t state_reg;
    logic load_clk_d_reg;
    logic page_latch_d_reg;
    logic wr_n_d_reg;
    logic prog_v_d_reg;
    logic [2:0] toggle_cnt_reg;
    logic [2:0] guard_cnt_reg;
    logic [7:0] cmd_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [7:0] data_lo_reg;
    logic [7:0] data_hi_reg;
    logic write_armed_reg;
    pnpp_op_t op_reg;
    pnpp_op_t op_next;
    logic start_op;

    logic [1:0] action;
    logic [1:0] bsel;
    logic [3:0] enable_pins;
    logic load_rise;
    logic latch_rise;
    logic wr_fall;
    logic volt_rise;
    logic ready;
    logic pbuf_we;
    logic [PAGE_WORD_BITS-1:0] pbuf_waddr;
    logic [15:0] pbuf_wdata;

    assign action = {i_action_select1, i_action_select0};
    assign bsel = {i_byte_select_hi, i_byte_select_lo};
    assign enable_pins = {i_page_latch_strobe, i_action_select1, i_action_select0,
                          i_byte_select_lo};
    assign load_rise = i_load_clock_pin && !load_clk_d_reg;
    assign latch_rise = i_page_latch_strobe && !page_latch_d_reg;
    assign wr_fall = !i_wr_n && wr_n_d_reg;
    assign volt_rise = i_prog_voltage && !prog_v_d_reg;
    assign ready = (state_reg == ST_READY);

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            load_clk_d_reg <= 1'b0;
            page_latch_d_reg <= 1'b0;
            wr_n_d_reg <= 1'b1;
            prog_v_d_reg <= 1'b0;
        end else if (i_ce) begin
            load_clk_d_reg <= i_load_clock_pin;
            page_latch_d_reg <= i_page_latch_strobe;
            wr_n_d_reg <= i_wr_n;
            prog_v_d_reg <= i_prog_voltage;
        end
    end

    // ------------------------------------------------------------
    // mode entry
    // ------------------------------------------------------------
    // load clock edges seen while the reset pin is low, saturating
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            toggle_cnt_reg <= 3'h0;
        end else if (i_ce) begin
            if (i_prog_voltage) begin
                if (state_reg == ST_OFF) begin
                    toggle_cnt_reg <= 3'h0;
                end
            end else if (load_rise && toggle_cnt_reg < MIN_LOAD_TOGGLES) begin
                toggle_cnt_reg <= toggle_cnt_reg + 3'h1;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            guard_cnt_reg <= 3'h0;
        end else if (i_ce) begin
            if (state_reg == ST_GUARD) begin
                guard_cnt_reg <= guard_cnt_reg + 3'h1;
            end else begin
                guard_cnt_reg <= 3'h0;
            end
        end
    end

    // ------------------------------------------------------------
    // main sequencer
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_reg <= ST_OFF;
        end else if (i_ce) begin
            if (!i_prog_voltage) begin
                // dropping the reset pin leaves the mode from any state
                state_reg <= ST_OFF;
            end else begin
                case (state_reg)
                    ST_OFF: begin
                        if (volt_rise && toggle_cnt_reg == MIN_LOAD_TOGGLES &&
                            enable_pins == ENABLE_PATTERN) begin
                            state_reg <= ST_GUARD;
                        end else if (volt_rise) begin
                            state_reg <= ST_REFUSED;
                        end
                    end
                    ST_GUARD: begin
                        if (enable_pins != ENABLE_PATTERN) begin
                            state_reg <= ST_REFUSED;
                        end else if (guard_cnt_reg == ENABLE_HOLD_CYC - 3'h1) begin
                            state_reg <= ST_READY;
                        end
                    end
                    ST_REFUSED: begin
                        state_reg <= ST_REFUSED;
                    end
                    ST_READY: begin
                        if (start_op) begin
                            state_reg <= ST_OP;
                        end
                    end
                    ST_OP: begin
                        if (i_op_done && op_next.kind == OP_NONE) begin
                            state_reg <= ST_READY;
                        end
                    end
                    default: begin
                        state_reg <= ST_OFF;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // load clock actions
    // ------------------------------------------------------------
    // loads are ignored while busy; the programmer waits for ready anyway
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cmd_reg <= CMD_NOP;
            write_armed_reg <= 1'b0;
        end else if (i_ce) begin
            if (state_reg == ST_OFF) begin
                cmd_reg <= CMD_NOP;
                write_armed_reg <= 1'b0;
            end else if (ready && load_rise && action == ACT_CMD) begin
                cmd_reg <= i_data;
                // nop ends a page session by dropping the write enable
                write_armed_reg <= (i_data == CMD_WRITE_FLASH) ||
                                   (i_data == CMD_WRITE_EEPROM);
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            addr_reg <= '0;
        end else if (i_ce && ready && load_rise && action == ACT_ADDR) begin
            case (bsel)
                BSEL_LOW: addr_reg[7:0] <= i_data;
                BSEL_HIGH: addr_reg[15:8] <= i_data;
                BSEL_EXT: addr_reg[23:16] <= i_data;
                default: addr_reg <= addr_reg;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            data_lo_reg <= 8'h00;
            data_hi_reg <= 8'h00;
        end else if (i_ce && ready && load_rise && action == ACT_DATA &&
                     !i_byte_select_hi) begin
            if (i_byte_select_lo) begin
                data_hi_reg <= i_data;
            end else begin
                data_lo_reg <= i_data;
            end
        end
    end

    // ------------------------------------------------------------
    // page buffer fill
    // ------------------------------------------------------------
    always_comb begin
        pbuf_we = 1'b0;
        pbuf_waddr = addr_reg[PAGE_WORD_BITS-1:0];
        pbuf_wdata = {data_hi_reg, data_lo_reg};
        if (ready && latch_rise && bsel == BSEL_HIGH && write_armed_reg) begin
            pbuf_we = 1'b1;
            if (cmd_reg == CMD_WRITE_EEPROM) begin
                pbuf_waddr = {{(PAGE_WORD_BITS-EE_PAGE_BITS){1'b0}},
                              addr_reg[EE_PAGE_BITS-1:0]};
                pbuf_wdata = {8'h00, data_lo_reg};
            end
        end
    end

    pnpp_page_buf u_page_buf (
        .i_clk(i_clk),
        .i_ce(i_ce),
        .i_we(pbuf_we),
        .i_waddr(pbuf_waddr),
        .i_wdata(pbuf_wdata),
        .i_raddr(i_pbuf_raddr),
        .o_rdata(o_pbuf_rdata)
    );

    // ------------------------------------------------------------
    // write strobe decode
    // ------------------------------------------------------------
    always_comb begin
        start_op = 1'b0;
        op_next = op_reg;
        if (state_reg == ST_READY) begin
            op_next.kind = OP_NONE;
            op_next.addr = addr_reg;
            op_next.data = data_lo_reg;
            op_next.fuse_sel = bsel;
            if (wr_fall) begin
                case (cmd_reg)
                    CMD_CHIP_ERASE: begin
                        op_next.kind = OP_ERASE_FLASH;
                    end
                    CMD_WRITE_FLASH: begin
                        if (bsel == BSEL_LOW && write_armed_reg) begin
                            op_next.kind = OP_WRITE_FLASH_PAGE;
                            // page base: bit 7 of the low byte joins the page, bits 6:0 cleared
                            op_next.addr = {addr_reg[ADDR_W-1:PAGE_WORD_BITS],
                                            {PAGE_WORD_BITS{1'b0}}};
                        end
                    end
                    CMD_WRITE_EEPROM: begin
                        if (bsel == BSEL_LOW && write_armed_reg) begin
                            op_next.kind = OP_WRITE_EEPROM_PAGE;
                            op_next.addr = {addr_reg[ADDR_W-1:EE_PAGE_BITS],
                                            {EE_PAGE_BITS{1'b0}}};
                        end
                    end
                    CMD_WRITE_FUSE: begin
                        if (bsel != BSEL_RSVD) begin
                            op_next.kind = OP_WRITE_FUSE;
                        end
                    end
                    CMD_WRITE_LOCK: begin
                        op_next.kind = OP_WRITE_LOCK;
                    end
                    default: begin
                        op_next.kind = OP_NONE;
                    end
                endcase
            end
            start_op = (op_next.kind != OP_NONE);
        end else if (state_reg == ST_OP && i_op_done) begin
            // erase steps run strictly in turn; locks go last, fuses never
            case (op_reg.kind)
                OP_ERASE_FLASH: begin
                    if (i_eeprom_preserve_fuse) begin
                        op_next.kind = OP_ERASE_EEPROM;
                    end else begin
                        op_next.kind = OP_ERASE_LOCK;
                    end
                end
                OP_ERASE_EEPROM: begin
                    op_next.kind = OP_ERASE_LOCK;
                end
                default: begin
                    op_next.kind = OP_NONE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            op_reg <= '0;
        end else if (i_ce) begin
            if (state_reg != ST_READY && state_reg != ST_OP) begin
                op_reg.kind <= OP_NONE;
            end else begin
                op_reg <= op_next;
            end
        end
    end

    assign o_op = op_reg;
    assign o_op_valid = (state_reg == ST_OP);
    assign o_ready_busy_out = ready;
    assign o_prog_mode = ready || (state_reg == ST_OP);

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_rd_req <= '0;
        end else if (i_ce) begin
            o_rd_req.addr <= addr_reg;
            case (cmd_reg)
                CMD_READ_FLASH: o_rd_req.space <= RD_FLASH;
                CMD_READ_EEPROM: o_rd_req.space <= RD_EEPROM;
                CMD_READ_SIG: o_rd_req.space <= RD_SIGNATURE;
                default: o_rd_req.space <= RD_NONE;
            endcase
        end
    end

    // one cycle behind the select pins; a 250 ns pulse covers it
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_data <= 8'h00;
        end else if (i_ce) begin
            case (cmd_reg)
                CMD_READ_FLASH: begin
                    o_data <= i_byte_select_lo ? i_rd_word[15:8] : i_rd_word[7:0];
                end
                CMD_READ_EEPROM: begin
                    o_data <= i_rd_word[7:0];
                end
                CMD_READ_SIG: begin
                    o_data <= i_byte_select_lo ? i_cal_byte : i_rd_word[7:0];
                end
                CMD_READ_FUSE: begin
                    case (bsel)
                        BSEL_LOW: o_data <= i_fuse_lock.fuse_low;
                        BSEL_HIGH: o_data <= i_fuse_lock.lock;
                        BSEL_EXT: o_data <= i_fuse_lock.fuse_ext;
                        default: o_data <= i_fuse_lock.fuse_high;
                    endcase
                end
                default: begin
                    o_data <= 8'h00;
                end
            endcase
        end
    end

    // combinational so the bus lets go in the same cycle oe rises
    assign o_data_oe = o_prog_mode && !i_oe_n;

endmodule // pnpp_port

// >>> tb/pnpp_props.sv
// port checker for pnpp_port, bound to every instance
// assumes one clock domain and the sync active-high reset
`timescale 1ns/1ps
module pnpp_props
    import pnpp_pkg::*;
(
    input wire logic i_clk, // clock
    input wire logic i_rst, // reset
    input wire logic i_prog_voltage, // pin
    input wire logic i_action_select0, // pin
    input wire logic i_action_select1, // pin
    input wire logic i_byte_select_lo, // pin
    input wire logic i_page_latch_strobe, // pin
    input wire logic i_wr_n, // pin
    input wire logic i_oe_n, // pin
    input wire logic i_eeprom_preserve_fuse, // fuse
    input wire logic i_op_done, // back end
    input wire logic o_data_oe, // out
    input wire logic o_ready_busy_out, // out
    input wire logic o_prog_mode, // out
    input wire pnpp_op_t o_op, // out
    input wire logic o_op_valid // out
);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    wire logic [3:0] en_pins = {i_page_latch_strobe, i_action_select1,
        i_action_select0, i_byte_select_lo};
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    bus_drive_a: assert property (o_data_oe == (o_prog_mode && !i_oe_n))
        else $error("data bus drive wrong");
    busy_op_a: assert property (o_op_valid || !o_prog_mode |-> !o_ready_busy_out)
        else $error("ready while busy");
    entry_guard_a: assert property ($rose(o_prog_mode) |-> $past(i_prog_voltage, 3)
        && !$past(i_prog_voltage, 4) && $past(en_pins) == 4'h0 && $past(en_pins, 2) == 4'h0
        && $past(en_pins, 3) == 4'h0) else $error("mode entered without clean guard");
    op_start_a: assert property ($rose(o_op_valid) |-> !$past(i_wr_n) && $past(i_wr_n, 2))
        else $error("operation not started by write strobe");
    op_hold_a: assert property (o_op_valid && !i_op_done |=> o_op_valid)
        else $error("operation dropped early");
    erase_next_a: assert property (o_op_valid && i_op_done && o_op.kind == OP_ERASE_FLASH
        |=> o_op_valid && o_op.kind == ($past(i_eeprom_preserve_fuse) ? OP_ERASE_EEPROM
        : OP_ERASE_LOCK)) else $error("erase chain order wrong");
    erase_end_a: assert property (o_op_valid && i_op_done && o_op.kind == OP_ERASE_LOCK
        |=> o_ready_busy_out && !o_op_valid) else $error("no ready after erase");
    page_align_a: assert property (o_op_valid && o_op.kind == OP_WRITE_FLASH_PAGE
        |-> o_op.addr[6:0] == 7'h0) else $error("page address not aligned");
    cover property (o_op_valid && i_op_done && o_op.kind == OP_ERASE_LOCK);
    cover property (o_op_valid && o_op.kind == OP_WRITE_FLASH_PAGE);
    cover property ($rose(o_prog_mode));
endmodule // pnpp_props
bind pnpp_port pnpp_props props_u (.i_clk, .i_rst, .i_prog_voltage, .i_action_select0,
    .i_action_select1, .i_byte_select_lo, .i_page_latch_strobe, .i_wr_n, .i_oe_n,
    .i_eeprom_preserve_fuse, .i_op_done, .o_data_oe, .o_ready_busy_out, .o_prog_mode,
    .o_op, .o_op_valid);

// >>> tb/pnpp_backend.sv
// behavioural array back end: finishes each operation after three cycles
// assumes op_valid is held until the done pulse is seen
`timescale 1ns/1ps
module pnpp_backend
    import pnpp_pkg::*;
(
    input wire logic i_clk, // clock
    input wire logic i_rst, // reset
    input wire logic i_op_valid, // operation pending
    input wire pnpp_rd_req_t i_rd_req, // read request
    output logic o_op_done, // done pulse
    output logic [15:0] o_rd_word // read word
);
    logic [1:0] cnt_reg;
    // word differs per low address byte so a stale address shows up
    assign o_rd_word = {~i_rd_req.addr[7:0], i_rd_req.addr[7:0]};
    always_ff @(posedge i_clk) begin
        if (i_rst || !i_op_valid || o_op_done) begin
            cnt_reg <= 2'h0;
            o_op_done <= 1'b0;
        end else begin
            cnt_reg <= cnt_reg + 2'h1;
            o_op_done <= (cnt_reg == 2'h2);
        end
    end
endmodule // pnpp_backend

// >>> tb/tb_parallel_nvm_programming_port.sv
// testbench: drives the programmer pins, back end model on the array side
// assumes 20 MHz clock and inputs changed on falling edges
`timescale 1ns/1ps
module tb_parallel_nvm_programming_port;
    import pnpp_pkg::*;
    logic clk = 1'b0, rst = 1'b1, pv = 1'b0, lc = 1'b0, pl = 1'b0, wr_n = 1'b1, oe_n = 1'b1;
    logic [1:0] act = 2'h0, bs = 2'h0;
    logic [7:0] din = 8'h00, dout;
    logic [6:0] pidx = 7'h0;
    logic [15:0] prd, rdw;
    logic oe, rdy, pm, opv, done;
    logic ees = 1'b1;
    logic [7:0] fexp [4] = '{8'ha1, 8'hd4, 8'hc3, 8'hb2};
    pnpp_op_t op;
    pnpp_rd_req_t rq;
    int errors = 0, total_checks = 0;
    initial begin
        forever #25 clk = ~clk;
    end
    pnpp_port dut_u (.i_clk(clk), .i_rst(rst), .i_ce(1'b1), .i_prog_voltage(pv),
        .i_load_clock_pin(lc), .i_action_select0(act[0]), .i_action_select1(act[1]),
        .i_byte_select_lo(bs[0]), .i_byte_select_hi(bs[1]), .i_page_latch_strobe(pl),
        .i_wr_n(wr_n), .i_oe_n(oe_n), .i_data(din), .o_data(dout), .o_data_oe(oe),
        .o_ready_busy_out(rdy), .o_prog_mode(pm), .i_eeprom_preserve_fuse(ees),
        .i_fuse_lock(32'ha1b2c3d4), .o_op(op), .o_op_valid(opv), .i_op_done(done),
        .o_rd_req(rq), .i_rd_word(rdw), .i_cal_byte(8'h3c), .i_pbuf_raddr(pidx),
        .o_pbuf_rdata(prd));
    pnpp_backend model_u (.i_clk(clk), .i_rst(rst), .i_op_valid(opv), .i_rd_req(rq),
        .o_op_done(done), .o_rd_word(rdw));
    // ------------------------------------------------------------
    // pin tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic ld(input logic [1:0] a, input logic [1:0] b, input logic [7:0] d);
        @(negedge clk);
        {act, bs, din, lc} = {a, b, d, 1'b1};
        @(negedge clk);
        lc = 1'b0;
    endtask
    task automatic pulse(input bit w); // w: write strobe, else page latch
        @(negedge clk);
        {wr_n, pl} = w ? 2'b00 : 2'b11;
        @(negedge clk);
        {wr_n, pl} = 2'b10;
    endtask
    task automatic wait_ready();
        for (int i = 0; i < 100 && rdy !== 1'b1; i++) @(negedge clk);
        check(rdy, 1'b1);
    endtask
    task automatic enter(input bit spoil);
        pv = 1'b0;
        repeat (6) ld(2'h0, 2'h0, 8'h00);
        @(negedge clk);
        pv = 1'b1;
        if (spoil) begin
            @(negedge clk);
            act = 2'h1;
        end
        repeat (5) @(negedge clk);
    endtask
    initial begin
        // tests take about 1150 cycles, mostly the wait after entry
        #150000;
        errors++;
        stop_test();
    end
    initial begin
        repeat (12) @(negedge clk);
        rst = 1'b0;
        check(rdy, 1'b0);
        enter(1'b1);
        check(pm, 1'b0);
        enter(1'b0);
        check(rdy, 1'b1);
        repeat (1000) @(negedge clk);
        ld(2'h2, 2'h0, CMD_CHIP_ERASE);
        pulse(1'b1);
        @(negedge clk);
        check(rdy, 1'b0);
        check(op.kind, OP_ERASE_FLASH);
        repeat (3) @(negedge clk);
        check(op.kind, OP_ERASE_EEPROM);
        wait_ready();
        check(rdy, 1'b1);
        ld(2'h2, 2'h0, CMD_WRITE_FLASH);
        ld(2'h0, 2'h0, 8'h85);
        ld(2'h0, 2'h1, 8'h12);
        ld(2'h0, 2'h2, 8'h03);
        ld(2'h0, 2'h3, 8'hff);
        ld(2'h1, 2'h0, 8'h34);
        ld(2'h1, 2'h2, 8'hee);
        ld(2'h1, 2'h1, 8'h56);
        pulse(1'b0);
        pidx = 7'h05;
        repeat (2) @(negedge clk);
        check(prd, 16'h5634);
        bs = 2'h0;
        pulse(1'b1);
        @(negedge clk);
        check(op.kind, OP_WRITE_FLASH_PAGE);
        check(op.addr, 24'h031280);
        wait_ready();
        ld(2'h2, 2'h0, CMD_READ_FLASH);
        oe_n = 1'b0;
        repeat (3) @(negedge clk);
        check(oe, 1'b1);
        check(dout, 8'h85);
        bs = 2'h1;
        repeat (2) @(negedge clk);
        check(dout, 8'h7a);
        ld(2'h2, 2'h0, CMD_READ_FUSE);
        for (int i = 0; i < 4; i++) begin
            bs = i[1:0];
            repeat (2) @(negedge clk);
            check(dout, fexp[i]);
        end
        ld(2'h2, 2'h1, CMD_READ_SIG);
        repeat (2) @(negedge clk);
        check(dout, 8'h3c);
        oe_n = 1'b1;
        @(negedge clk);
        check(oe, 1'b0);
        ld(2'h2, 2'h0, CMD_NOP);
        pulse(1'b1);
        @(negedge clk);
        check(rdy, 1'b1);
        // disarmed after nop: a latch must leave the buffer alone
        ld(2'h1, 2'h0, 8'h99);
        bs = 2'h1;
        pulse(1'b0);
        repeat (2) @(negedge clk);
        check(prd, 16'h5634);
        ld(2'h2, 2'h0, CMD_WRITE_FUSE);
        bs = 2'h2;
        pulse(1'b1);
        @(negedge clk);
        check({op.kind, op.fuse_sel, op.data}, {OP_WRITE_FUSE, 2'h2, 8'h99});
        wait_ready();
        // preserve fuse programmed: the eeprom step is skipped
        ees = 1'b0;
        ld(2'h2, 2'h0, CMD_CHIP_ERASE);
        pulse(1'b1);
        repeat (4) @(negedge clk);
        check(op.kind, OP_ERASE_LOCK);
        wait_ready();
        stop_test();
    end
endmodule // tb_parallel_nvm_programming_port
